/* mac_cfg_pkg.sv */
// constants and types shared by the mac configuration block
// Behaviour
// - rx vlan enable bit 27: accept tagged frames, max payload grows four bytes
// - length/type check off bit 25 skips length/type field validation
// - control length check off bit 24 accepts long control frames
// - bit 22 adds in-line timestamp besides out-of-band delivery
// - without ptp support the in-line timestamp bit has no effect
// - rx word bits 21 to 16 always read zero
// - bits 15:0 hold address 47:32; full address matches rx pause dest
// - tx uses the same address as pause frame source address
// - first wire byte of address sits in lowest register byte
// - basic vlan recognises only tag protocol id 0x8100
// - tx word written anytime, applied only in inter-frame gap
// - tx reset bit 31 acts immediately, no gap deferral
// - tx reset resets transmitter, restores tx defaults, self-clears
// - tx jumbo bit 30, reset one, allows oversize transmission
// - rx word written anytime, applied only in inter-frame gap
package mac_cfg_pkg;
	localparam logic [11:0] PAUSE_LO_OFS  = 12'h0400;
	localparam logic [11:0] RX_WORD1_OFS  = 12'h0404;
	localparam logic [11:0] TX_WORD_OFS   = 12'h0408;
	localparam int          RX_VLAN_BIT   = 27;
	localparam int          RX_DUPLEX_BIT = 26;
	localparam int          RX_LT_OFF_BIT = 25;
	localparam int          RX_CL_OFF_BIT = 24;
	localparam int          RX_TS_BIT     = 22;
	localparam int          TX_RST_BIT    = 31;
	localparam int          TX_JUMBO_BIT  = 30;
	localparam logic [31:0] PAUSE_LO_RST  = 32'hDDCC_BBAA;
	localparam logic [15:0] PAUSE_HI_RST  = 16'hFFEE;
	localparam logic [31:0] RX_WR_MASK    = 32'h0F40_FFFF;
	localparam logic [31:0] RX_RST        = 32'h0800_FFEE;
	localparam logic [31:0] TX_WR_MASK    = 32'h4000_0000;
	localparam logic [31:0] TX_RST        = 32'h4000_0000;
	localparam logic [15:0] VLAN_TAG_ID   = 16'h8100;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;
endpackage

/* mac_cfg_if.sv */
`timescale 1ns/1ps
// settings bundle from the register file to the gap-sync stage
interface mac_cfg_if;
	logic [31:0] rx_word;  // programmed rx word
	logic [31:0] tx_word;  // programmed tx word
	logic        gap;      // line idle: settings may change
	logic        tx_rst;   // immediate transmitter reset request
	logic [31:0] rx_live;  // rx word in force
	logic [31:0] tx_live;  // tx word in force
	modport regs (output rx_word, tx_word, gap, tx_rst,
		input rx_live, tx_live);
	modport sync (input rx_word, tx_word, gap, tx_rst,
		output rx_live, tx_live);
endinterface

/* mac_cfg_gap_sync.sv */
`timescale 1ns/1ps
// holds the settings in force and refreshes them only between frames, save a tx reset which restores tx defaults at once
module mac_cfg_gap_sync
	import mac_cfg_pkg::*;
(
	input wire logic clock_i, // system clock
	input wire logic rst_i,   // async reset, high
	mac_cfg_if.sync  cfg      // settings bundle
);
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cfg.rx_live <= RX_RST;
		end else if (cfg.gap) begin
			cfg.rx_live <= cfg.rx_word;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cfg.tx_live <= TX_RST;
		end else if (cfg.tx_rst) begin
			cfg.tx_live <= TX_RST;
		end else if (cfg.gap) begin
			cfg.tx_live <= cfg.tx_word;
		end
	end

	property p_tx_hold;
		@(posedge clock_i) disable iff (rst_i)
		!cfg.gap && !cfg.tx_rst |=> $stable(cfg.tx_live);
	endproperty
	a_tx_hold: assert property (p_tx_hold)
		else $error("tx settings changed mid-frame");
	property p_rx_hold;
		@(posedge clock_i) disable iff (rst_i)
		!cfg.gap |=> $stable(cfg.rx_live);
	endproperty
	a_rx_hold: assert property (p_rx_hold)
		else $error("rx settings changed mid-frame");
endmodule // mac_cfg_gap_sync

/* mac_rx_tx_config.sv */
`timescale 1ns/1ps
// ethernet mac rx/tx configuration registers with axi4-lite slave
module mac_rx_tx_config
	import mac_cfg_pkg::*;
#(
	parameter bit PTP_PRESENT = 1'b1  // build includes timestamp support
)(
	input  wire logic        clock_i,           // 100 MHz clock
	input  wire logic        rst_i,             // async reset, high
	input  wire logic [11:0] s_axi_awaddr,      // write address
	input  wire logic        s_axi_awvalid,     // write address valid
	output logic             s_axi_awready,     // write address ready
	input  wire logic [31:0] s_axi_wdata,       // write data
	input  wire logic [3:0]  s_axi_wstrb,       // byte enables
	input  wire logic        s_axi_wvalid,      // write data valid
	output logic             s_axi_wready,      // write data ready
	output logic [1:0]       s_axi_bresp,       // write response
	output logic             s_axi_bvalid,      // write response valid
	input  wire logic        s_axi_bready,      // write response ready
	input  wire logic [11:0] s_axi_araddr,      // read address
	input  wire logic        s_axi_arvalid,     // read address valid
	output logic             s_axi_arready,     // read address ready
	output logic [31:0]      s_axi_rdata,       // read data
	output logic [1:0]       s_axi_rresp,       // read response
	output logic             s_axi_rvalid,      // read data valid
	input  wire logic        s_axi_rready,      // read data ready
	input  wire logic        rx_gap_i,          // rx path between frames
	input  wire logic        tx_gap_i,          // tx path between frames
	input  wire logic [15:0] rx_type_i,         // rx length/type field
	input  wire logic [47:0] rx_dest_addr_i,    // rx destination address
	output logic             rx_vlan_en_o,      // accept tagged frames
	output logic             rx_is_vlan_o,      // frame is tagged
	output logic [2:0]       rx_max_extra_o,    // extra payload bytes
	output logic             duplex_select_o,   // rx half duplex (unused)
	output logic             lentype_check_off_o, // skip length/type check
	output logic             ctrl_len_check_off_o,// accept long ctrl frames
	output logic             rx_ts_inline_o,    // in-line timestamp
	output logic             rx_pause_match_o,  // dest equals station addr
	output logic [47:0]      flow_ctrl_station_addr_o, // pause frame source
	output logic             oversize_frame_en_o, // tx jumbo allowed
	output logic             tx_reset_o         // transmitter reset pulse
);
	import mac_cfg_pkg::*;

	localparam logic [2:0] VLAN_EXTRA = 3'd4;

	logic [31:0] pause_lo_q;
	logic [31:0] rx_word_q;
	logic [31:0] tx_word_q;
	logic        tx_rst_q;
	logic        aw_held_q;
	logic        w_held_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        wr_go;
	logic        rd_go;
	logic [47:0] addr_rx;
	logic [47:0] addr_tx;

	mac_cfg_if cfg ();

	mac_cfg_gap_sync u_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.cfg     (cfg)
	);

	// apply bytes selected by wstrb under a mask of writable bits
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be,
		input logic [31:0] mask);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
		merge = (old & ~m) | (nw & m);
	endfunction

	// write channel: address and data accepted in either order
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			aw_held_q <= 1'b0;
			awaddr_q  <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			w_held_q <= 1'b0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			wdata_q  <= s_axi_wdata;
			wstrb_q  <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			unique case (awaddr_q)
				PAUSE_LO_OFS, RX_WORD1_OFS, TX_WORD_OFS:
					s_axi_bresp <= RESP_OKAY;
				default: s_axi_bresp <= RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// pause address low word takes effect at once, without the rx gap rule of the rx word
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pause_lo_q <= PAUSE_LO_RST;
		end else if (wr_go && awaddr_q == PAUSE_LO_OFS) begin
			pause_lo_q <= merge(pause_lo_q, wdata_q, wstrb_q, 32'hFFFF_FFFF);
		end
	end

	// bits 23 and 21:16 are outside the mask so they stay zero
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rx_word_q <= RX_RST;
		end else if (wr_go && awaddr_q == RX_WORD1_OFS) begin
			rx_word_q <= merge(rx_word_q, wdata_q, wstrb_q, RX_WR_MASK);
		end
	end

	// tx reset never lands in the stored word; it pulses and restores
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			tx_word_q <= TX_RST;
			tx_rst_q  <= 1'b0;
		end else if (wr_go && awaddr_q == TX_WORD_OFS && wstrb_q[3]
			&& wdata_q[TX_RST_BIT]) begin
			tx_word_q <= TX_RST;
			tx_rst_q  <= 1'b1;
		end else begin
			tx_rst_q <= 1'b0;
			if (wr_go && awaddr_q == TX_WORD_OFS) begin
				tx_word_q <= merge(tx_word_q, wdata_q, wstrb_q, TX_WR_MASK);
			end
		end
	end

	assign cfg.rx_word = rx_word_q;
	assign cfg.tx_word = tx_word_q;
	assign cfg.gap     = rx_gap_i && tx_gap_i;
	assign cfg.tx_rst  = tx_rst_q;

	// read channel: one cycle to answer
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			unique case (s_axi_araddr)
				PAUSE_LO_OFS: s_axi_rdata <= pause_lo_q;
				RX_WORD1_OFS: s_axi_rdata <= rx_word_q & RX_WR_MASK;
				TX_WORD_OFS:  s_axi_rdata <= tx_word_q & TX_WR_MASK;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// lowest register byte is the first on the wire
	assign addr_rx = {cfg.rx_live[15:0], pause_lo_q};
	assign addr_tx = addr_rx;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rx_vlan_en_o         <= 1'b1;
			rx_is_vlan_o         <= 1'b0;
			rx_max_extra_o       <= VLAN_EXTRA;
			duplex_select_o      <= 1'b0;
			lentype_check_off_o  <= 1'b0;
			ctrl_len_check_off_o <= 1'b0;
			rx_ts_inline_o       <= 1'b0;
			rx_pause_match_o     <= 1'b0;
		end else begin
			rx_vlan_en_o   <= cfg.rx_live[RX_VLAN_BIT];
			rx_is_vlan_o   <= cfg.rx_live[RX_VLAN_BIT]
				&& rx_type_i == VLAN_TAG_ID;
			rx_max_extra_o <= cfg.rx_live[RX_VLAN_BIT] ? VLAN_EXTRA
				: 3'd0;
			duplex_select_o      <= cfg.rx_live[RX_DUPLEX_BIT];
			lentype_check_off_o  <= cfg.rx_live[RX_LT_OFF_BIT];
			ctrl_len_check_off_o <= cfg.rx_live[RX_CL_OFF_BIT];
			rx_ts_inline_o <= PTP_PRESENT
				&& cfg.rx_live[RX_TS_BIT];
			rx_pause_match_o <= rx_dest_addr_i == addr_rx;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			flow_ctrl_station_addr_o <= {PAUSE_HI_RST, PAUSE_LO_RST};
			oversize_frame_en_o      <= 1'b1;
		end else begin
			flow_ctrl_station_addr_o <= addr_tx;
			oversize_frame_en_o <= cfg.tx_live[TX_JUMBO_BIT];
		end
	end

	assign tx_reset_o = tx_rst_q;

	property p_rx_rsvd;
		@(posedge clock_i) disable iff (rst_i)
		rd_go && s_axi_araddr == RX_WORD1_OFS |=>
			s_axi_rdata[23] == 1'b0 && s_axi_rdata[21:16] == 6'h00;
	endproperty
	a_rx_rsvd: assert property (p_rx_rsvd)
		else $error("reserved rx bits read nonzero");

	sequence s_rst_write;
		wr_go && awaddr_q == TX_WORD_OFS && wstrb_q[3]
			&& wdata_q[TX_RST_BIT];
	endsequence
	property p_tx_reset;
		@(posedge clock_i) disable iff (rst_i)
		// live settings need one edge, the output one more
		s_rst_write |=> tx_reset_o ##1 !tx_reset_o
			##1 oversize_frame_en_o == TX_RST[TX_JUMBO_BIT];
	endproperty
	a_tx_reset: assert property (p_tx_reset)
		else $error("tx reset did not pulse and restore");

	property p_ts_gate;
		@(posedge clock_i) disable iff (rst_i)
		rx_ts_inline_o == (PTP_PRESENT && $past(cfg.rx_live[RX_TS_BIT]));
	endproperty
	a_ts_gate: assert property (p_ts_gate)
		else $error("inline timestamp active without ptp");

	property p_vlan_extra;
		@(posedge clock_i) disable iff (rst_i)
		rx_max_extra_o == (rx_vlan_en_o ? VLAN_EXTRA : 3'd0);
	endproperty
	a_vlan_extra: assert property (p_vlan_extra)
		else $error("vlan payload allowance wrong");

	property p_tag_id;
		@(posedge clock_i) disable iff (rst_i)
		rx_is_vlan_o |-> $past(rx_type_i) == VLAN_TAG_ID && rx_vlan_en_o;
	endproperty
	a_tag_id: assert property (p_tag_id)
		else $error("tag seen without 0x8100");

	property p_src_addr;
		@(posedge clock_i) disable iff (rst_i)
		##1 flow_ctrl_station_addr_o[15:0] == $past(pause_lo_q[15:0]);
	endproperty
	a_src_addr: assert property (p_src_addr)
		else $error("station address byte order wrong");

	property p_lt;
		@(posedge clock_i) disable iff (rst_i)
		lentype_check_off_o == $past(cfg.rx_live[RX_LT_OFF_BIT]);
	endproperty
	a_lt: assert property (p_lt)
		else $error("length/type check control wrong");

	property p_cl;
		@(posedge clock_i) disable iff (rst_i)
		ctrl_len_check_off_o == $past(cfg.rx_live[RX_CL_OFF_BIT]);
	endproperty
	a_cl: assert property (p_cl)
		else $error("control length check control wrong");

	property p_jumbo;
		@(posedge clock_i) disable iff (rst_i)
		oversize_frame_en_o == $past(cfg.tx_live[TX_JUMBO_BIT]);
	endproperty
	a_jumbo: assert property (p_jumbo)
		else $error("tx jumbo enable not following live settings");

	// the whole 48-bit value takes part in the match, not one word
	property p_pause_match;
		@(posedge clock_i) disable iff (rst_i)
		rx_pause_match_o == ($past(rx_dest_addr_i)
			== {$past(cfg.rx_live[15:0]), $past(pause_lo_q)});
	endproperty
	a_pause_match: assert property (p_pause_match)
		else $error("pause destination match wrong");
endmodule // mac_rx_tx_config

/* mac_rx_tx_config_tb_top.sv */
`timescale 1ns/1ps
// self-checking bench for the mac rx/tx configuration block
module mac_rx_tx_config_tb_top;
	import mac_cfg_pkg::*;
	logic        clock_i, rst_i, rx_gap_i, tx_gap_i;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, w, p, plo;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, rx_vlan_en_o, rx_is_vlan_o;
	logic        duplex_select_o, lentype_check_off_o, ctrl_len_check_off_o;
	logic        rx_ts_inline_o, rx_pause_match_o, oversize_frame_en_o;
	logic        tx_reset_o;
	logic [2:0]  rx_max_extra_o;
	logic [15:0] rx_type_i, t;
	logic [47:0] rx_dest_addr_i, flow_ctrl_station_addr_o;
	integer      n_fail = 0, n_tests = 0, n_pulse = 0, seed = 73731;

	mac_rx_tx_config mac_rx_tx_config_inst (
		.clock_i(clock_i), .rst_i(rst_i),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .rx_gap_i(rx_gap_i),
		.tx_gap_i(tx_gap_i), .rx_type_i(rx_type_i),
		.rx_dest_addr_i(rx_dest_addr_i), .rx_vlan_en_o(rx_vlan_en_o),
		.rx_is_vlan_o(rx_is_vlan_o), .rx_max_extra_o(rx_max_extra_o),
		.duplex_select_o(duplex_select_o),
		.lentype_check_off_o(lentype_check_off_o),
		.ctrl_len_check_off_o(ctrl_len_check_off_o),
		.rx_ts_inline_o(rx_ts_inline_o),
		.rx_pause_match_o(rx_pause_match_o),
		.flow_ctrl_station_addr_o(flow_ctrl_station_addr_o),
		.oversize_frame_en_o(oversize_frame_en_o),
		.tx_reset_o(tx_reset_o)
	);

	always #5 clock_i = ~clock_i;

	// the reset pulse lasts one cycle, so it is counted rather than sampled
	always @(posedge clock_i) begin
		if (tx_reset_o === 1'b1) n_pulse <= n_pulse + 1;
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// extra edge at the end keeps back-to-back calls from double driving
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= s;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge clock_i);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge clock_i);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		axi_read(a, rd, rs);
		chk(rd, ed);
		chk(rs, er);
	endtask

	// a tagged frame may carry four more payload bytes
	function automatic logic [2:0] exp_extra(input logic vlan_en);
		exp_extra = vlan_en ? 3'h4 : 3'h0;
	endfunction

	task automatic chk_rx(input logic [31:0] x, input logic [31:0] lo);
		chk(rx_vlan_en_o, x[RX_VLAN_BIT]);
		chk(rx_max_extra_o, exp_extra(x[RX_VLAN_BIT]));
		chk(duplex_select_o, x[RX_DUPLEX_BIT]);
		chk(lentype_check_off_o, x[RX_LT_OFF_BIT]);
		chk(ctrl_len_check_off_o, x[RX_CL_OFF_BIT]);
		chk(rx_ts_inline_o, x[RX_TS_BIT]);
		chk(flow_ctrl_station_addr_o, {x[15:0], lo});
	endtask

	initial begin
		repeat (5000) @(posedge clock_i);
		n_fail++;
		conclude();
	end

	initial begin
		clock_i = 1'b0;
		rst_i = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, rx_gap_i, tx_gap_i} = '0;
		rx_type_i = '0;
		rx_dest_addr_i = '0;
		repeat (20) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		chk_rx(RX_RST, PAUSE_LO_RST);
		chk(oversize_frame_en_o, 1'b1);
		rd_chk(RX_WORD1_OFS, RX_RST, RESP_OKAY);
		rd_chk(TX_WORD_OFS, TX_RST, RESP_OKAY);
		// partial strobe: only lanes 0 and 2 change
		axi_write(PAUSE_LO_OFS, 32'h1122_3344, 4'h5, rs);
		plo = 32'hDD22_BB44;
		repeat (2) @(posedge clock_i);
		chk(flow_ctrl_station_addr_o, {PAUSE_HI_RST, plo});
		rd_chk(PAUSE_LO_OFS, plo, RESP_OKAY);
		// rx word must wait until both paths sit between frames
		// duplex stays at full
		axi_write(RX_WORD1_OFS, 32'hFBFF_FFFF, 4'hF, rs);
		rx_gap_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		chk_rx(RX_RST, plo);
		rd_chk(RX_WORD1_OFS, RX_WR_MASK & 32'hFBFF_FFFF, RESP_OKAY);
		tx_gap_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		chk_rx(RX_WR_MASK & 32'hFBFF_FFFF, plo);
		// basic vlan only, no extended mode
		for (int i = 0; i < 8; i++) begin
			w = $random(seed) & 32'hFBFF_FFFF;
			p = $random(seed);
			if (i == 0) w = 32'h0000_0000;
			if (i == 1) w = w | 32'h0800_0000;
			t = i[0] ? VLAN_TAG_ID : 16'($random(seed));
			axi_write(RX_WORD1_OFS, w, 4'hF, rs);
			axi_write(PAUSE_LO_OFS, p, 4'hF, rs);
			rx_type_i <= t;
			rx_dest_addr_i <= {w[15:0], p ^ {31'h0, ~i[1]}};
			repeat (4) @(posedge clock_i);
			chk_rx(w & RX_WR_MASK, p);
			chk(rx_is_vlan_o, w[RX_VLAN_BIT] && t == VLAN_TAG_ID);
			chk(rx_pause_match_o, i[1]);
			rd_chk(RX_WORD1_OFS, w & RX_WR_MASK, RESP_OKAY);
		end
		// tx word deferred to the gap, reset bit acts at once
		rx_gap_i <= 1'b0;
		tx_gap_i <= 1'b0;
		axi_write(TX_WORD_OFS, 32'h0000_0000, 4'hF, rs);
		repeat (4) @(posedge clock_i);
		chk(oversize_frame_en_o, 1'b1);
		rd_chk(TX_WORD_OFS, 32'h0000_0000, RESP_OKAY);
		rx_gap_i <= 1'b1;
		tx_gap_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		chk(oversize_frame_en_o, 1'b0);
		rx_gap_i <= 1'b0;
		tx_gap_i <= 1'b0;
		axi_write(TX_WORD_OFS, 32'h8000_0000, 4'hF, rs);
		repeat (2) @(posedge clock_i);
		chk(oversize_frame_en_o, 1'b1);
		chk(n_pulse, 1);
		rd_chk(TX_WORD_OFS, TX_RST, RESP_OKAY);
		// a tx-only reset is followed by a full one
		rx_dest_addr_i <= '0;
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		chk_rx(RX_RST, PAUSE_LO_RST);
		chk(oversize_frame_en_o, 1'b1);
		rd_chk(TX_WORD_OFS, TX_RST, RESP_OKAY);
		// unmapped place answers with an error and reads zero
		axi_write(12'h40C, 32'hFFFF_FFFF, 4'hF, rs);
		chk(rs, RESP_SLVERR);
		rd_chk(12'h40C, 32'h0000_0000, RESP_SLVERR);
		conclude();
	end
endmodule // mac_rx_tx_config_tb_top
